/* verilog/emal_consts.vh */
// shared constants for the error mask and alert block
// assumes: included by the design files by bare name
`ifndef EMAL_CONSTS_VH
`define EMAL_CONSTS_VH
// register byte offsets
`define EMAL_A_CFG 8'h00
`define EMAL_A_SLEEP_STATE 8'h01
`define EMAL_A_SLEEP_MASK 8'h02
`define EMAL_A_GPI_MASK 8'h03
`define EMAL_A_MISC_MASK 8'h04
`define EMAL_A_USER_LIM 8'h05
`define EMAL_A_MGMT_STAT0 8'h08
`define EMAL_A_MGMT_STAT1 8'h0C
`define EMAL_A_HOST_STAT0 8'h30
`define EMAL_A_HOST_STAT1 8'h34
`define EMAL_A_VHI0 8'h10
`define EMAL_A_THI0 8'h20
`define EMAL_A_TACH0 8'h28
// config fields
`define EMAL_CFG_ALERT_EN 0
`define EMAL_CFG_COMPAT 1
// mask and reset values
`define EMAL_V_MASKVAL 8'hFF
`define EMAL_T_MASKVAL 8'h80
`define EMAL_TACH_MASKVAL 8'hFF
`define EMAL_USER_MASKVAL 8'hFF
`define EMAL_ZERO8 8'h00
`define EMAL_ZERO32 32'h00000000
// sleep states: s0 none, s1 force-masks fans, s3 also optional masks
`define EMAL_SLEEP_FULL 8'h03
`define EMAL_SLEEP_MID 8'h01
`endif

/* verilog/emal_sync.v */
// three-flop synchroniser for a bus of asynchronous event inputs
// assumes: inputs arrive from pins outside the clk domain
`include "emal_consts.vh"
module emal_sync #(
    parameter W = 8
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    dout[i] <= 1'b0;
                end
                else
                begin
                    s1[i] <= din[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    // change counts only once stages two and three agree
                    if (s2[i] == s3[i])
                        dout[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule // emal_sync

/* verilog/emal_top.v */
// error masking, sticky status latching and alert output
// assumes: raw event levels come from pins; software uses the plain register port
//
// Functional notes
// - masked event never sets management or host status bit
// - masking leaves an already set status bit alone
// - voltage high limit FFh masks channel; FFh is reset value
// - temperature high limit 80h masks channel; 80h is reset value
// - masked temperature channel suppresses over-temperature and diode fault
// - general input mask bit suppresses that general input's errors
// - user throttle event masked while user limit is FFh
// - fixed throttle threshold bits have no mask, always set
// - fixed throttle bits never drive error outputs or alert
// - tach limit FFh masks that fan tach channel
// - regulator overheat masked by its miscellaneous mask bit
// - alert disabled after power-up until software enables it
// - alert output gated by the alert enable configuration bit
// - some events always masked in certain sleep states
// - other events masked in sleep state 03h when sleep mask bit set
// - status bits stay set until software clears them
// - write-one clears only if the causing event is gone
// - management and host clears are independent
// - compat mode: management status read clears, host unaffected
//
// The address-and-strobe port and the register addresses were decided locally.
`include "emal_consts.vh"
module emal_top #(
    parameter NV = 16,
    parameter NT = 4,
    parameter NF = 4,
    parameter NG = 8,
    parameter NR = 2
) (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [NV-1:0] volt_err_in,
    input wire [NT-1:0] temp_err_in,
    input wire [NT-1:0] diode_fault_in,
    input wire [NF-1:0] tach_err_in,
    input wire [NG-1:0] general_input,
    input wire [NR-1:0] regulator_overheat_in,
    input wire user_throttle_in,
    input wire [1:0] cpu_throttle_indicator,
    output reg mgmt_error_out,
    output reg host_error_out,
    output reg alert_out
);
    // status word: [15:0] volt, [19:16] temp, [23:20] diode, [27:24] tach
    // word1: [3:0] gpi 7:4 (gpi 3:0 in word0 [31:28]), [5:4] vrd, [6] user throttle, [8:7] fixed throttle
    localparam NIN = NV + 2 * NT + NF + NG + NR + 3;
    // word1 holds whatever does not fit in word0
    localparam NW1 = NIN - 32;

    wire [NIN-1:0] raw_async;
    wire [NIN-1:0] ev;
    assign raw_async = {cpu_throttle_indicator, user_throttle_in, regulator_overheat_in,
        general_input, tach_err_in, diode_fault_in, temp_err_in, volt_err_in};

    emal_sync #(.W(NIN)) u_sync (
        .clk(clk),
        .rst(rst),
        .din(raw_async),
        .dout(ev)
    );

    reg [7:0] cfg;
    reg [7:0] sleep_state;
    reg [7:0] sleep_mask;
    reg [7:0] gpi_mask;
    reg [7:0] misc_mask;
    reg [7:0] user_lim;
    reg [7:0] vhi [0:NV-1];
    reg [7:0] thi [0:NT-1];
    reg [7:0] tlim [0:NF-1];
    reg [NIN-1:0] mstat;
    reg [NIN-1:0] hstat;
    reg [NIN-1:0] mask;
    reg [NIN-1:0] next_mstat;
    reg [NIN-1:0] next_hstat;
    reg [NIN-1:0] wclr_m;
    reg [NIN-1:0] wclr_h;
    reg [NIN-1:0] alert_cap;
    reg [31:0] next_rdata;
    reg rclr_m;
    reg [31:0] wd;
    integer k;

    // mask vector assembled per event
    always @*
    begin
        mask = {NIN{1'b0}};
        for (k = 0; k < NV; k = k + 1)
            mask[k] = (vhi[k] == `EMAL_V_MASKVAL);
        for (k = 0; k < NT; k = k + 1)
        begin
            mask[NV + k] = (thi[k] == `EMAL_T_MASKVAL);
            mask[NV + NT + k] = (thi[k] == `EMAL_T_MASKVAL);
        end
        for (k = 0; k < NF; k = k + 1)
        begin
            mask[NV + 2 * NT + k] = (tlim[k] == `EMAL_TACH_MASKVAL)
                || (sleep_state != `EMAL_ZERO8);
        end
        for (k = 0; k < NG; k = k + 1)
            mask[NV + 2 * NT + NF + k] = gpi_mask[k]
                || ((sleep_state == `EMAL_SLEEP_FULL) && sleep_mask[0]);
        for (k = 0; k < NR; k = k + 1)
            mask[NV + 2 * NT + NF + NG + k] = misc_mask[k]
                || ((sleep_state == `EMAL_SLEEP_FULL) && sleep_mask[1]);
        mask[NIN - 3] = (user_lim == `EMAL_USER_MASKVAL);
        mask[NIN - 2] = 1'b0;
        mask[NIN - 1] = 1'b0;
        alert_cap = {NIN{1'b1}};
        alert_cap[NIN - 1] = 1'b0;
        alert_cap[NIN - 2] = 1'b0;
    end

    // write and read-clear decode, then status update
    always @*
    begin
        wd = reg_wdata;
        wclr_m = {NIN{1'b0}};
        wclr_h = {NIN{1'b0}};
        rclr_m = reg_rd && cfg[`EMAL_CFG_COMPAT];
        if (reg_wr && reg_addr == `EMAL_A_MGMT_STAT0)
            wclr_m[31:0] = wd;
        if (reg_wr && reg_addr == `EMAL_A_MGMT_STAT1)
            wclr_m[NIN-1:32] = wd[NW1-1:0];
        if (reg_wr && reg_addr == `EMAL_A_HOST_STAT0)
            wclr_h[31:0] = wd;
        if (reg_wr && reg_addr == `EMAL_A_HOST_STAT1)
            wclr_h[NIN-1:32] = wd[NW1-1:0];
        if (rclr_m && reg_addr == `EMAL_A_MGMT_STAT0)
            wclr_m[31:0] = {32{1'b1}};
        if (rclr_m && reg_addr == `EMAL_A_MGMT_STAT1)
            wclr_m[NIN-1:32] = {NW1{1'b1}};
        // active event blocks clear; new set wins over clear
        next_mstat = (mstat & ~(wclr_m & ~ev)) | (ev & ~mask);
        next_hstat = (hstat & ~(wclr_h & ~ev)) | (ev & ~mask);
    end

    // read mux; unmapped addresses read zero
    always @*
    begin
        next_rdata = `EMAL_ZERO32;
        case (reg_addr)
            `EMAL_A_CFG: next_rdata[7:0] = cfg;
            `EMAL_A_SLEEP_STATE: next_rdata[7:0] = sleep_state;
            `EMAL_A_SLEEP_MASK: next_rdata[7:0] = sleep_mask;
            `EMAL_A_GPI_MASK: next_rdata[7:0] = gpi_mask;
            `EMAL_A_MISC_MASK: next_rdata[7:0] = misc_mask;
            `EMAL_A_USER_LIM: next_rdata[7:0] = user_lim;
            `EMAL_A_MGMT_STAT0: next_rdata = mstat[31:0];
            `EMAL_A_MGMT_STAT1: next_rdata[NW1-1:0] = mstat[NIN-1:32];
            `EMAL_A_HOST_STAT0: next_rdata = hstat[31:0];
            `EMAL_A_HOST_STAT1: next_rdata[NW1-1:0] = hstat[NIN-1:32];
            default:
            begin
                for (k = 0; k < NV; k = k + 1)
                    if (reg_addr == `EMAL_A_VHI0 + k[7:0])
                        next_rdata[7:0] = vhi[k];
                for (k = 0; k < NT; k = k + 1)
                    if (reg_addr == `EMAL_A_THI0 + k[7:0])
                        next_rdata[7:0] = thi[k];
                for (k = 0; k < NF; k = k + 1)
                    if (reg_addr == `EMAL_A_TACH0 + k[7:0])
                        next_rdata[7:0] = tlim[k];
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NV; g = g + 1)
        begin : g_vhi
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    vhi[g] <= `EMAL_V_MASKVAL;
                else if (reg_wr && reg_addr == `EMAL_A_VHI0 + g)
                    vhi[g] <= reg_wdata[7:0];
            end
        end
        for (g = 0; g < NT; g = g + 1)
        begin : g_thi
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    thi[g] <= `EMAL_T_MASKVAL;
                else if (reg_wr && reg_addr == `EMAL_A_THI0 + g)
                    thi[g] <= reg_wdata[7:0];
            end
        end
        for (g = 0; g < NF; g = g + 1)
        begin : g_tach
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    tlim[g] <= `EMAL_TACH_MASKVAL;
                else if (reg_wr && reg_addr == `EMAL_A_TACH0 + g)
                    tlim[g] <= reg_wdata[7:0];
            end
        end
    endgenerate

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg <= `EMAL_ZERO8;
            sleep_state <= `EMAL_ZERO8;
            sleep_mask <= `EMAL_ZERO8;
            gpi_mask <= `EMAL_ZERO8;
            misc_mask <= `EMAL_ZERO8;
            user_lim <= `EMAL_USER_MASKVAL;
            mstat <= {NIN{1'b0}};
            hstat <= {NIN{1'b0}};
            reg_rdata <= `EMAL_ZERO32;
            mgmt_error_out <= 1'b0;
            host_error_out <= 1'b0;
            alert_out <= 1'b0;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `EMAL_A_CFG: cfg <= reg_wdata[7:0];
                    `EMAL_A_SLEEP_STATE: sleep_state <= reg_wdata[7:0];
                    `EMAL_A_SLEEP_MASK: sleep_mask <= reg_wdata[7:0];
                    `EMAL_A_GPI_MASK: gpi_mask <= reg_wdata[7:0];
                    `EMAL_A_MISC_MASK: misc_mask <= reg_wdata[7:0];
                    `EMAL_A_USER_LIM: user_lim <= reg_wdata[7:0];
                    default: cfg <= cfg;
                endcase
            end
            mstat <= next_mstat;
            hstat <= next_hstat;
            reg_rdata <= reg_rd ? next_rdata : `EMAL_ZERO32;
            // outputs lag status by one cycle; fixed throttle bits excluded
            mgmt_error_out <= |(mstat & alert_cap);
            host_error_out <= |(hstat & alert_cap);
            alert_out <= cfg[`EMAL_CFG_ALERT_EN] && |((mstat | hstat) & alert_cap);
        end
    end
endmodule // emal_top

/* tb/emal_chk_sva.sv */
// checker for the error mask and alert block
// assumes: bound to emal_top; one clock, async active-high reset
`include "emal_consts.vh"
module emal_chk #(
    parameter NV = 16,
    parameter NT = 4,
    parameter NF = 4,
    parameter NG = 8,
    parameter NR = 2
) (
    input logic clk,
    input logic rst,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    input logic [NV-1:0] volt_err_in,
    input logic [NT-1:0] temp_err_in,
    input logic [NT-1:0] diode_fault_in,
    input logic [NF-1:0] tach_err_in,
    input logic [NG-1:0] general_input,
    input logic [NR-1:0] regulator_overheat_in,
    input logic user_throttle_in,
    input logic mgmt_error_out,
    input logic host_error_out,
    input logic alert_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_h;
    logic vmask_h;
    logic [2:0] acc_h;
    logic [3:0] quiet;
    // throttle indicator left out: it must never raise an output
    wire ev_any = |{volt_err_in, temp_err_in, diode_fault_in, tach_err_in, general_input,
        regulator_overheat_in, user_throttle_in};
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_h <= 1'b0;
            vmask_h <= 1'b1;
            acc_h <= 3'h0;
            quiet <= 4'hF;
        end
        else
        begin
            if (reg_wr && reg_addr == `EMAL_A_CFG)
                en_h <= reg_wdata[`EMAL_CFG_ALERT_EN];
            if (reg_wr && reg_addr == `EMAL_A_VHI0)
                vmask_h <= (reg_wdata[7:0] == `EMAL_V_MASKVAL);
            acc_h <= {acc_h[1:0], reg_wr | reg_rd};
            quiet <= ev_any ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    alert_gated_a: assert property (!en_h && !$past(en_h) |-> !alert_out)
        else $error("alert high while disabled");
    alert_cause_a: assert property (alert_out |-> mgmt_error_out || host_error_out)
        else $error("alert without error output");
    alert_follow_a: assert property (en_h && $past(en_h) && mgmt_error_out
        && $past(mgmt_error_out) |-> alert_out) else $error("alert missing");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    volt_set_a: assert property ((!vmask_h && volt_err_in[0]) [*6]
        |=> mgmt_error_out && host_error_out) else $error("unmasked event not latched");
    mgmt_sticky_a: assert property ($fell(mgmt_error_out) |-> acc_h != 3'h0)
        else $error("management error fell without access");
    mgmt_cause_a: assert property ($rose(mgmt_error_out) |-> quiet < 4'h8)
        else $error("management error without event");
    host_cause_a: assert property ($rose(host_error_out) |-> quiet < 4'h8)
        else $error("host error without event");
    cover property ($rose(alert_out));
    cover property ($fell(mgmt_error_out));
    cover property (reg_rd && reg_addr == `EMAL_A_MGMT_STAT0);
endmodule // emal_chk
bind emal_top emal_chk #(.NV(NV), .NT(NT), .NF(NF), .NG(NG), .NR(NR)) emal_chk_i (.*);

/* tb/emal_mc.sv */
// management controller model: drives the register port
// assumes: strobes one cycle, read data in the cycle after the strobe
module emal_mc (
    input logic clk,
    output logic [7:0] reg_addr = 8'h00,
    output logic [31:0] reg_wdata = 32'h0,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    input logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // cfg and sleep state writes go through here
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // emal_mc

/* tb/test_error_mask_alert_logic.sv */
// bench for the error mask and alert block
// assumes: emal_top defaults, 25 MHz clock
`include "emal_consts.vh"
module test_error_mask_alert_logic;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [40:0] V0 = 41'h1 << 25;
    localparam logic [40:0] T0 = 41'h1 << 21;
    localparam logic [40:0] D0 = 41'h1 << 17;
    localparam logic [40:0] F0 = 41'h1 << 13;
    localparam logic [40:0] G0 = 41'h1 << 5;
    localparam logic [7:0] ST = `EMAL_A_MGMT_STAT0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, mgmt_error_out, host_error_out, alert_out;
    logic [15:0] volt_err_in = 16'h0;
    logic [3:0] temp_err_in = 4'h0, diode_fault_in = 4'h0, tach_err_in = 4'h0;
    logic [7:0] general_input = 8'h0;
    logic [1:0] regulator_overheat_in = 2'h0, cpu_throttle_indicator = 2'h0;
    logic user_throttle_in = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    emal_top emal_top_i (.*);
    emal_mc emal_mc_i (.*);
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        emal_mc_i.rd(a, d);
        chk(d, exp);
    endtask
    // events pass a three-flop synchroniser, so hold each level 8 cycles
    task automatic evs(input logic [40:0] v);
        @(posedge clk);
        {volt_err_in, temp_err_in, diode_fault_in, tach_err_in, general_input,
            regulator_overheat_in, user_throttle_in, cpu_throttle_indicator} <= v;
        repeat (8) @(posedge clk);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk(`EMAL_A_CFG, 32'h0);
        rchk(`EMAL_A_VHI0, 32'hFF);
        rchk(`EMAL_A_THI0, 32'h80);
        rchk(`EMAL_A_TACH0, 32'hFF);
        rchk(`EMAL_A_USER_LIM, 32'hFF);
        rchk(8'hFF, 32'h0);
        emal_mc_i.wr(`EMAL_A_GPI_MASK, 32'hFF);
        emal_mc_i.wr(`EMAL_A_MISC_MASK, 32'h3);
        evs('1);
        evs('0);
        rchk(ST, 32'h0);
        chk({29'h0, mgmt_error_out, host_error_out, alert_out}, 32'h0);
        rchk(`EMAL_A_MGMT_STAT1, 32'h180);
        rchk(`EMAL_A_HOST_STAT1, 32'h180);
        emal_mc_i.wr(`EMAL_A_VHI0, 32'h7F);
        evs(V0);
        rchk(ST, 32'h1);
        chk({31'h0, alert_out}, 32'h0);
        emal_mc_i.wr(`EMAL_A_CFG, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, alert_out}, 32'h1);
        emal_mc_i.wr(ST, 32'h1);
        rchk(ST, 32'h1);
        evs('0);
        emal_mc_i.wr(`EMAL_A_VHI0, 32'hFF);
        rchk(ST, 32'h1);
        emal_mc_i.wr(ST, 32'h1);
        rchk(ST, 32'h0);
        repeat (3) @(posedge clk);
        chk({29'h0, mgmt_error_out, host_error_out, alert_out}, 32'h3);
        emal_mc_i.wr(`EMAL_A_CFG, 32'h3);
        emal_mc_i.wr(`EMAL_A_THI0, 32'h50);
        evs(T0 | D0);
        evs('0);
        rchk(ST, 32'h00110000);
        rchk(ST, 32'h0);
        chk({31'h0, host_error_out}, 32'h1);
        emal_mc_i.wr(`EMAL_A_CFG, 32'h1);
        emal_mc_i.wr(`EMAL_A_SLEEP_STATE, 32'h1);
        emal_mc_i.wr(`EMAL_A_TACH0, 32'h10);
        evs(F0);
        evs('0);
        rchk(ST, 32'h0);
        emal_mc_i.wr(`EMAL_A_SLEEP_STATE, 32'h3);
        emal_mc_i.wr(`EMAL_A_SLEEP_MASK, 32'h1);
        emal_mc_i.wr(`EMAL_A_GPI_MASK, 32'h0);
        evs(G0);
        evs('0);
        rchk(ST, 32'h0);
        emal_mc_i.wr(`EMAL_A_SLEEP_STATE, 32'h0);
        evs(F0 | G0);
        evs('0);
        rchk(ST, 32'h11000000);
        end_sim();
    end
endmodule // test_error_mask_alert_logic
